//--- src/mte_pkg.sv
// package for the multi-transfer and exception-entry control block
// assumes a single core clock and priorities where lower value is more urgent
`default_nettype none

package mte_pkg;

	// ==========================================================
	// widths and types
	localparam int CONT_W = 4;
	localparam int PRI_W = 9;
	localparam int NUM_W = 9;
	localparam int ADDR_W = 32;

	typedef logic [CONT_W-1:0] mte_cont_t;
	typedef logic signed [PRI_W-1:0] mte_pri_t;
	typedef logic [NUM_W-1:0] mte_num_t;
	typedef logic [ADDR_W-1:0] mte_addr_t;

	// ==========================================================
	// derived exception classes seen during entry
	typedef enum logic [2:0]
	{
		MTE_DER_NONE,
		MTE_DER_PROT_STACK,
		MTE_DER_BUS_STACK,
		MTE_DER_WATCH,
		MTE_DER_VECTOR
	} mte_der_t;

	// ==========================================================
	// fixed values
	localparam mte_pri_t HARD_FAULT_PRI = 9'sh1FF; // escalated priority, -1
	localparam mte_cont_t CONT_NONE = 4'h0; // all zero: no continuation held
	// exception numbers handed to the entry logic
	localparam mte_num_t EXC_HARD_FAULT = 9'h003;
	localparam mte_num_t EXC_PROT_FAULT = 9'h004;
	localparam mte_num_t EXC_BUS_FAULT = 9'h005;
	localparam mte_num_t EXC_WATCH_TRAP = 9'h00C;

	// ==========================================================
	// values after reset
	localparam mte_addr_t RST_ADDR = 32'h0000_0000;
	localparam mte_num_t RST_NUM = 9'h000;
	localparam mte_pri_t RST_PRI = 9'sh000;

endpackage

`default_nettype wire

//--- src/mte_if.sv
// carriers between the control top and its two decision modules
// assumes the top drives the inputs and samples the answers combinationally
`default_nettype none

// ==========================================================
// multi-register transfer abandon information
interface mte_xfer_if;
	import mte_pkg::*;
	logic is_load;
	logic dir_db;
	logic writeback;
	logic base_is_sp;
	logic in_cond;
	logic base_in_list;
	logic base_loaded;
	logic is_fault;
	logic cont_en;
	mte_cont_t next_reg;
	mte_addr_t base_init;
	mte_addr_t base_final;
	mte_addr_t base_val;
	logic cont_wr;
	mte_cont_t cont_val;
	logic restart;
	modport ctrl (output is_load, dir_db, writeback, base_is_sp, in_cond, base_in_list,
		base_loaded, is_fault, cont_en, next_reg, base_init, base_final,
		input base_val, cont_wr, cont_val, restart);
	modport calc (input is_load, dir_db, writeback, base_is_sp, in_cond, base_in_list,
		base_loaded, is_fault, cont_en, next_reg, base_init, base_final,
		output base_val, cont_wr, cont_val, restart);
endinterface

// ==========================================================
// exception entry arbitration information
interface mte_entry_if;
	import mte_pkg::*;
	mte_num_t orig_num;
	mte_pri_t orig_pri;
	logic late_vld;
	logic late_en;
	mte_num_t late_num;
	mte_pri_t late_pri;
	mte_pri_t preempt_pri;
	logic der_prot;
	logic der_bus;
	logic der_watch;
	logic der_vec;
	mte_pri_t prot_pri;
	mte_pri_t bus_pri;
	mte_pri_t watch_pri;
	mte_num_t take_num;
	mte_pri_t take_pri;
	logic pend_vld;
	mte_num_t pend_num;
	mte_der_t der_class;
	logic der_drop;
	modport ctrl (output orig_num, orig_pri, late_vld, late_en, late_num, late_pri,
		preempt_pri, der_prot, der_bus, der_watch, der_vec, prot_pri, bus_pri, watch_pri,
		input take_num, take_pri, pend_vld, pend_num, der_class, der_drop);
	modport calc (input orig_num, orig_pri, late_vld, late_en, late_num, late_pri,
		preempt_pri, der_prot, der_bus, der_watch, der_vec, prot_pri, bus_pri, watch_pri,
		output take_num, take_pri, pend_vld, pend_num, der_class, der_drop);
endinterface

`default_nettype wire

//--- src/mte_xfer_resolve.sv
// base register value and continuation choice for an abandoned transfer
// assumes inputs describe the transfer at the moment the exception hits it
`default_nettype none

module mte_xfer_resolve
	import mte_pkg::*;
(
	// decision carrier
	mte_xfer_if.calc x
);

	// ==========================================================
	// resolution
	always_comb
	begin
		x.base_val = x.base_init;
		x.cont_wr = 1'b0;
		x.cont_val = CONT_NONE;
		x.restart = 1'b1;
		if (x.is_fault)
		begin
			// base back to its start, whole re-run on return
			x.base_val = x.base_init;
			x.cont_wr = !x.in_cond;
			x.cont_val = CONT_NONE;
		end
		else if (x.is_load && x.base_in_list)
		begin
			x.base_val = x.base_init;
			if (x.in_cond)
				x.cont_wr = 1'b0;
			else if (x.cont_en && !x.base_loaded)
			begin
				x.cont_wr = 1'b1;
				x.cont_val = x.next_reg;
				x.restart = 1'b0;
			end
			else
			begin
				x.cont_wr = 1'b1;
				x.cont_val = CONT_NONE;
			end
		end
		else if (x.in_cond)
		begin
			x.base_val = x.base_init;
		end
		else if (!x.cont_en)
		begin
			x.base_val = x.base_init;
			x.cont_wr = 1'b1;
		end
		else
		begin
			x.cont_wr = 1'b1;
			x.cont_val = x.next_reg;
			x.restart = 1'b0;
			if (x.base_is_sp)
				x.base_val = x.dir_db ? x.base_final : x.base_init;
			else if (x.writeback)
				x.base_val = x.base_final;
		end
	end

endmodule

`default_nettype wire

//--- src/mte_entry_arb.sv
// choice of handler and pending state at the end of exception entry
// assumes derived events are already filtered for halting debug
`default_nettype none

module mte_entry_arb
	import mte_pkg::*;
(
	// decision carrier
	mte_entry_if.calc e
);

	mte_num_t de_num;
	mte_pri_t de_pri;
	logic done;

	// ==========================================================
	// pick the derived exception, most severe first
	always_comb
	begin
		e.der_class = MTE_DER_NONE;
		de_num = EXC_HARD_FAULT;
		de_pri = HARD_FAULT_PRI;
		if (e.der_vec)
			e.der_class = MTE_DER_VECTOR;
		else if (e.der_prot)
		begin
			e.der_class = MTE_DER_PROT_STACK;
			de_num = EXC_PROT_FAULT;
			de_pri = e.prot_pri;
		end
		else if (e.der_bus)
		begin
			e.der_class = MTE_DER_BUS_STACK;
			de_num = EXC_BUS_FAULT;
			de_pri = e.bus_pri;
		end
		else if (e.der_watch)
		begin
			e.der_class = MTE_DER_WATCH;
			de_num = EXC_WATCH_TRAP;
			de_pri = e.watch_pri;
		end
	end

	// ==========================================================
	// decide what is entered and what is left pending
	always_comb
	begin
		e.take_num = e.orig_num;
		e.take_pri = e.orig_pri;
		e.pend_vld = 1'b0;
		e.pend_num = e.orig_num;
		e.der_drop = 1'b0;
		done = 1'b0;
		if (e.der_class == MTE_DER_VECTOR)
		begin
			e.take_num = EXC_HARD_FAULT;
			e.take_pri = HARD_FAULT_PRI;
			e.pend_vld = 1'b1;
			done = 1'b1;
		end
		else if (e.der_class != MTE_DER_NONE && de_pri >= e.preempt_pri)
		begin
			if (e.der_class == MTE_DER_WATCH)
				e.der_drop = 1'b1;
			else
			begin
				e.take_num = EXC_HARD_FAULT;
				e.take_pri = HARD_FAULT_PRI;
				e.pend_vld = 1'b1;
				done = 1'b1;
			end
		end
		else if (e.der_class != MTE_DER_NONE)
		begin
			done = 1'b1;
			e.pend_vld = 1'b1;
			if (e.late_en && de_pri < e.orig_pri)
			begin
				e.take_num = de_num;
				e.take_pri = de_pri;
			end
			else
				e.pend_num = de_num;
		end
		if (!done && e.late_en && e.late_vld && e.late_pri < e.orig_pri)
		begin
			e.take_num = e.late_num;
			e.take_pri = e.late_pri;
			e.pend_vld = 1'b1;
			e.pend_num = e.orig_num;
		end
	end

endmodule

`default_nettype wire

//--- src/mte_exc_ctrl.sv
// top of the multi-transfer abandon and exception-entry control block
// assumes the pipeline reports transfer state and entry events synchronously
//
// Functional notes
// - fault on transfer: restore base register
// - fault: zero continuation unless in conditional block
// - after fault, re-run transfer from start
// - conditional block interrupt: base initial, no continuation
// - stack base: hand over lowest stack address
// - other base, write-back: final value, continuation
// - base-loading load abandoned: restore base
// - base-loading load in block: restart, no field
// - before base loaded: may record continuation
// - after base loaded: restore base
// - otherwise restart whole, continuation field zeroed
// - late interrupt reuses running entry sequence
// - late one active, original stays pending
// - late preempts only with lower priority value
// - classify stacking faults; watchpoint gives watch trap
// - vector fetch bus error becomes hard fault
// - drop watch trap, else escalate to -1
// - compare only preempted and derived priority
// - derived late arrival only above original
// - no late arrival: derived becomes pending
// - late arrival: derived active, original pending
// - field holds first register still to move
// - zero field means no continuation held
`default_nettype none

module mte_exc_ctrl
	import mte_pkg::*;
#(
	parameter bit CONT_SUPPORT = 1'b1,
	parameter bit LATE_SUPPORT = 1'b1
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// transfer description from the pipeline
	input wire logic xfer_active,
	input wire logic xfer_is_load,
	input wire logic xfer_dir_db,
	input wire logic xfer_writeback,
	input wire logic xfer_base_is_sp,
	input wire logic xfer_in_cond_block,
	input wire logic xfer_base_in_list,
	input wire logic xfer_base_loaded,
	input wire mte_cont_t xfer_next_reg,
	input wire mte_addr_t xfer_base_init,
	input wire mte_addr_t xfer_base_final,
	// events hitting the transfer
	input wire logic xfer_fault,
	input wire logic xfer_irq,
	// transfer resolution
	output logic xfer_done_ff,
	output mte_addr_t base_value_ff,
	output logic cont_wr_ff,
	output mte_cont_t continuation_field_ff,
	output logic restart_ff,
	// exception entry control
	input wire logic entry_start,
	input wire logic entry_decide,
	input wire mte_num_t orig_num,
	input wire mte_pri_t orig_pri,
	input wire mte_pri_t preempt_pri,
	input wire logic late_req,
	input wire mte_num_t late_num,
	input wire mte_pri_t late_pri,
	// derived events during entry
	input wire logic stack_prot_err,
	input wire logic stack_bus_err,
	input wire logic watch_hit,
	input wire logic halt_debug_en,
	input wire logic vector_bus_err,
	input wire mte_pri_t prot_pri,
	input wire mte_pri_t bus_pri,
	input wire mte_pri_t watch_pri,
	// entry decision
	output logic take_vld_ff,
	output mte_num_t take_num_ff,
	output mte_pri_t take_pri_ff,
	output logic pend_vld_ff,
	output mte_num_t pend_num_ff,
	output mte_der_t der_class_ff,
	output logic der_drop_ff,
	output logic entry_busy_ff
);

	// ==========================================================
	// reset release
	logic rst_meta_ff;
	logic rst_sync_ff;
	logic rst_n_int;

	// two stage release of the asynchronous reset
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	assign rst_n_int = rst_sync_ff;

	// ==========================================================
	// transfer abandon
	mte_xfer_if xi ();
	logic xfer_hit;

	// fault wins over interrupt when both arrive together
	assign xfer_hit = xfer_active && (xfer_fault || xfer_irq);
	assign xi.is_load = xfer_is_load;
	assign xi.dir_db = xfer_dir_db;
	assign xi.writeback = xfer_writeback;
	assign xi.base_is_sp = xfer_base_is_sp;
	assign xi.in_cond = xfer_in_cond_block;
	assign xi.base_in_list = xfer_base_in_list;
	assign xi.base_loaded = xfer_base_loaded;
	assign xi.is_fault = xfer_fault;
	assign xi.cont_en = CONT_SUPPORT;
	assign xi.next_reg = xfer_next_reg;
	assign xi.base_init = xfer_base_init;
	assign xi.base_final = xfer_base_final;

	mte_xfer_resolve u_resolve
	(
		.x (xi)
	);

	// one cycle resolution pulse
	always_ff @(posedge clk or negedge rst_n_int)
	begin
		if (!rst_n_int)
			xfer_done_ff <= 1'b0;
		else
			xfer_done_ff <= xfer_hit;
	end

	// base value handed back to the register file
	always_ff @(posedge clk or negedge rst_n_int)
	begin
		if (!rst_n_int)
			base_value_ff <= RST_ADDR;
		else if (xfer_hit)
			base_value_ff <= xi.base_val;
	end

	// continuation field and its write strobe
	always_ff @(posedge clk or negedge rst_n_int)
	begin
		if (!rst_n_int)
		begin
			cont_wr_ff <= 1'b0;
			continuation_field_ff <= CONT_NONE;
		end
		else
		begin
			cont_wr_ff <= xfer_hit && xi.cont_wr;
			if (xfer_hit && xi.cont_wr)
				continuation_field_ff <= xi.cont_val;
		end
	end

	// restart from the first register on return
	always_ff @(posedge clk or negedge rst_n_int)
	begin
		if (!rst_n_int)
			restart_ff <= 1'b0;
		else if (xfer_hit)
			restart_ff <= xi.restart;
	end

	// ==========================================================
	// exception entry sequence tracking
	typedef enum logic
	{
		ENT_IDLE,
		ENT_STACK
	} mte_ent_state_t;

	mte_ent_state_t state_ff;
	mte_ent_state_t nxt_state;
	logic prot_seen_ff;
	logic bus_seen_ff;
	logic watch_seen_ff;
	logic vec_seen_ff;
	logic decide;
	logic watch_ev;

	// a watchpoint only traps when halting debug is off
	assign watch_ev = watch_hit && !halt_debug_en;
	assign decide = (state_ff == ENT_STACK) && entry_decide;

	// entry state sequence
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ENT_IDLE:
				if (entry_start)
					nxt_state = ENT_STACK;
			ENT_STACK:
				if (entry_decide)
					nxt_state = ENT_IDLE;
			default:
				nxt_state = ENT_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_int)
	begin
		if (!rst_n_int)
			state_ff <= ENT_IDLE;
		else
			state_ff <= nxt_state;
	end

	// sticky derived events, consumed at the decision point
	always_ff @(posedge clk or negedge rst_n_int)
	begin
		if (!rst_n_int)
		begin
			prot_seen_ff <= 1'b0;
			bus_seen_ff <= 1'b0;
			watch_seen_ff <= 1'b0;
			vec_seen_ff <= 1'b0;
		end
		else if (decide || state_ff == ENT_IDLE)
		begin
			prot_seen_ff <= 1'b0;
			bus_seen_ff <= 1'b0;
			watch_seen_ff <= 1'b0;
			vec_seen_ff <= 1'b0;
		end
		else
		begin
			prot_seen_ff <= prot_seen_ff || stack_prot_err;
			bus_seen_ff <= bus_seen_ff || stack_bus_err;
			watch_seen_ff <= watch_seen_ff || watch_ev;
			vec_seen_ff <= vec_seen_ff || vector_bus_err;
		end
	end

	// ==========================================================
	// entry arbitration
	mte_entry_if ei ();

	// events in the decision cycle itself still count
	assign ei.orig_num = orig_num;
	assign ei.orig_pri = orig_pri;
	assign ei.late_vld = late_req;
	assign ei.late_en = LATE_SUPPORT;
	assign ei.late_num = late_num;
	assign ei.late_pri = late_pri;
	assign ei.preempt_pri = preempt_pri;
	assign ei.der_prot = prot_seen_ff || stack_prot_err;
	assign ei.der_bus = bus_seen_ff || stack_bus_err;
	assign ei.der_watch = watch_seen_ff || watch_ev;
	assign ei.der_vec = vec_seen_ff || vector_bus_err;
	assign ei.prot_pri = prot_pri;
	assign ei.bus_pri = bus_pri;
	assign ei.watch_pri = watch_pri;

	mte_entry_arb u_arb
	(
		.e (ei)
	);

	// decision pulse and busy level
	always_ff @(posedge clk or negedge rst_n_int)
	begin
		if (!rst_n_int)
		begin
			take_vld_ff <= 1'b0;
			pend_vld_ff <= 1'b0;
			entry_busy_ff <= 1'b0;
		end
		else
		begin
			take_vld_ff <= decide;
			pend_vld_ff <= decide && ei.pend_vld;
			entry_busy_ff <= (nxt_state == ENT_STACK);
		end
	end

	// decision values, held until the next decision
	always_ff @(posedge clk or negedge rst_n_int)
	begin
		if (!rst_n_int)
		begin
			take_num_ff <= RST_NUM;
			take_pri_ff <= RST_PRI;
			pend_num_ff <= RST_NUM;
			der_class_ff <= MTE_DER_NONE;
			der_drop_ff <= 1'b0;
		end
		else if (decide)
		begin
			take_num_ff <= ei.take_num;
			take_pri_ff <= ei.take_pri;
			pend_num_ff <= ei.pend_num;
			der_class_ff <= ei.der_class;
			der_drop_ff <= ei.der_drop;
		end
	end

endmodule

`default_nettype wire

//--- tb/mte_exc_monitor.sv
// port checker for the exception control top
// assumes one clock domain, bound onto every mte_exc_ctrl instance
`default_nettype none

module mte_exc_monitor
	import mte_pkg::*;
#(
	parameter bit CONT_SUPPORT = 1'b1,
	parameter bit LATE_SUPPORT = 1'b1
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// transfer description and events
	input wire logic xfer_active,
	input wire logic xfer_is_load,
	input wire logic xfer_dir_db,
	input wire logic xfer_writeback,
	input wire logic xfer_base_is_sp,
	input wire logic xfer_in_cond_block,
	input wire logic xfer_base_in_list,
	input wire logic xfer_base_loaded,
	input wire mte_cont_t xfer_next_reg,
	input wire mte_addr_t xfer_base_init,
	input wire mte_addr_t xfer_base_final,
	input wire logic xfer_fault,
	input wire logic xfer_irq,
	// transfer resolution
	input wire logic xfer_done_ff,
	input wire mte_addr_t base_value_ff,
	input wire logic cont_wr_ff,
	input wire mte_cont_t continuation_field_ff,
	input wire logic restart_ff,
	// entry inputs
	input wire logic entry_decide,
	input wire mte_num_t orig_num,
	input wire mte_pri_t orig_pri,
	input wire logic late_req,
	input wire mte_pri_t late_pri,
	// entry decision
	input wire logic take_vld_ff,
	input wire mte_num_t take_num_ff,
	input wire mte_pri_t take_pri_ff,
	input wire logic pend_vld_ff,
	input wire mte_num_t pend_num_ff,
	input wire mte_der_t der_class_ff,
	input wire logic entry_busy_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// shorthands
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// interrupt without fault, and a load that holds its own base
	wire logic irq_hit = xfer_active && xfer_irq && !xfer_fault;
	wire logic ld_base = xfer_is_load && xfer_base_in_list;

	// ==========================================================
	// transfer resolution
	a_done_pulse: assert property (
		xfer_done_ff == $past(xfer_active && (xfer_fault || xfer_irq)))
		else $error("done pulse does not follow a hit");
	a_fault_restore: assert property (xfer_active && xfer_fault |=>
		base_value_ff == $past(xfer_base_init) && restart_ff)
		else $error("fault did not restore base");
	a_fault_cont_zero: assert property (xfer_active && xfer_fault |=>
		cont_wr_ff == !$past(xfer_in_cond_block) && (!cont_wr_ff || continuation_field_ff == 0))
		else $error("fault field handling wrong");
	a_cond_irq_keep: assert property (irq_hit && xfer_in_cond_block |=>
		!cont_wr_ff && restart_ff && base_value_ff == $past(xfer_base_init))
		else $error("block interrupt handling wrong");
	a_sp_lowest: assert property (irq_hit && !xfer_in_cond_block && xfer_base_is_sp
		&& !ld_base && CONT_SUPPORT |=> cont_wr_ff && !restart_ff
		&& base_value_ff == ($past(xfer_dir_db) ? $past(xfer_base_final) : $past(xfer_base_init)))
		else $error("stack base not lowest address");
	a_other_final: assert property (irq_hit && !xfer_in_cond_block && !xfer_base_is_sp
		&& xfer_writeback && !ld_base && CONT_SUPPORT |=> base_value_ff == $past(xfer_base_final)
		&& continuation_field_ff == $past(xfer_next_reg))
		else $error("write-back base not final");
	a_load_restore: assert property (irq_hit && ld_base |=>
		base_value_ff == $past(xfer_base_init))
		else $error("base-loading load not restored");
	a_loaded_zero: assert property (irq_hit && ld_base && !xfer_in_cond_block
		&& xfer_base_loaded |=> cont_wr_ff && continuation_field_ff == CONT_NONE && restart_ff)
		else $error("loaded base did not clear field");

	// ==========================================================
	// entry decision
	a_decide_answer: assert property (entry_busy_ff && entry_decide |=>
		take_vld_ff ##1 !take_vld_ff)
		else $error("decision pulse missing");
	a_late_choice: assert property (take_vld_ff && der_class_ff == MTE_DER_NONE
		&& LATE_SUPPORT |-> take_pri_ff == ($past(late_req) && $past(late_pri) < $past(orig_pri)
		? $past(late_pri) : $past(orig_pri)))
		else $error("late arrival choice wrong");
	a_vector_hard: assert property (take_vld_ff && der_class_ff == MTE_DER_VECTOR |->
		take_num_ff == EXC_HARD_FAULT && take_pri_ff == HARD_FAULT_PRI && pend_vld_ff
		&& pend_num_ff == $past(orig_num))
		else $error("vector error not escalated");
endmodule

bind mte_exc_ctrl mte_exc_monitor #(.CONT_SUPPORT(CONT_SUPPORT), .LATE_SUPPORT(LATE_SUPPORT))
	u_mte_exc_monitor (.clk, .rst_n, .xfer_active, .xfer_is_load, .xfer_dir_db,
	.xfer_writeback, .xfer_base_is_sp, .xfer_in_cond_block, .xfer_base_in_list,
	.xfer_base_loaded, .xfer_next_reg, .xfer_base_init, .xfer_base_final, .xfer_fault,
	.xfer_irq, .xfer_done_ff, .base_value_ff, .cont_wr_ff, .continuation_field_ff, .restart_ff,
	.entry_decide, .orig_num, .orig_pri, .late_req, .late_pri, .take_vld_ff, .take_num_ff,
	.take_pri_ff, .pend_vld_ff, .pend_num_ff, .der_class_ff, .entry_busy_ff);

`default_nettype wire

//--- tb/mte_src_model.sv
// stacking memory and vector fetch model raising entry faults
// assumes the bench requests at most one fault class per entry
`default_nettype none

module mte_src_model
(
	// clock
	input wire logic clk,
	// request: prot, bus, watch, vector
	input wire logic [3:0] err_sel,
	input wire logic err_go,
	// entry faults toward the block
	output logic stack_prot_err,
	output logic stack_bus_err,
	output logic watch_hit,
	output logic vector_bus_err
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// one-cycle fault pulses, launched just after the edge
	initial {stack_prot_err, stack_bus_err, watch_hit, vector_bus_err} = 4'h0;
	always @(posedge clk)
		{stack_prot_err, stack_bus_err, watch_hit, vector_bus_err} <= err_go ? err_sel : 4'h0;
endmodule

`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the exception control top
// assumes the checker is bound and the fault model drives the entry faults
`default_nettype none

module testbench import mte_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// signals
	logic clk, rst_n, xfer_active, xfer_is_load, xfer_dir_db, xfer_writeback, xfer_base_is_sp;
	logic xfer_in_cond_block, xfer_base_in_list, xfer_base_loaded, xfer_fault, xfer_irq;
	logic entry_start, entry_decide, late_req, halt_debug_en, err_go;
	logic stack_prot_err, stack_bus_err, watch_hit, vector_bus_err;
	logic xfer_done_ff, cont_wr_ff, restart_ff, take_vld_ff, pend_vld_ff, der_drop_ff;
	logic entry_busy_ff;
	logic [3:0] err_sel;
	mte_cont_t xfer_next_reg, continuation_field_ff;
	mte_addr_t xfer_base_init, xfer_base_final, base_value_ff;
	mte_num_t orig_num, late_num, take_num_ff, pend_num_ff;
	mte_pri_t orig_pri, preempt_pri, late_pri, prot_pri, bus_pri, watch_pri, take_pri_ff;
	mte_der_t der_class_ff;
	int errors = 0;
	int tests_run = 0;
	int cycles = 0;

	mte_exc_ctrl u_mte_exc_ctrl (.clk, .rst_n, .xfer_active, .xfer_is_load, .xfer_dir_db,
		.xfer_writeback, .xfer_base_is_sp, .xfer_in_cond_block, .xfer_base_in_list,
		.xfer_base_loaded, .xfer_next_reg, .xfer_base_init, .xfer_base_final, .xfer_fault,
		.xfer_irq, .xfer_done_ff, .base_value_ff, .cont_wr_ff, .continuation_field_ff,
		.restart_ff, .entry_start, .entry_decide, .orig_num, .orig_pri, .preempt_pri, .late_req,
		.late_num, .late_pri, .stack_prot_err, .stack_bus_err, .watch_hit, .halt_debug_en,
		.vector_bus_err, .prot_pri, .bus_pri, .watch_pri, .take_vld_ff, .take_num_ff,
		.take_pri_ff, .pend_vld_ff, .pend_num_ff, .der_class_ff, .der_drop_ff, .entry_busy_ff);
	mte_src_model u_mte_src_model (.clk, .err_sel, .err_go, .stack_prot_err, .stack_bus_err,
		.watch_hit, .vector_bus_err);

	// ==========================================================
	// clock, hang guard and shared tasks
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			errors++;
			test_done();
		end
	end
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		tests_run++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected at %0t: %s got %0h want %0h", $time, m, g, e);
		end
	endtask
	// f: active fault irq load db writeback sp cond in_list loaded
	task automatic hit(input logic [9:0] f, input mte_cont_t n, input logic ef, input logic wr,
		input logic rs);
		{xfer_active, xfer_fault, xfer_irq, xfer_is_load, xfer_dir_db, xfer_writeback,
			xfer_base_is_sp, xfer_in_cond_block, xfer_base_in_list, xfer_base_loaded} = f;
		xfer_next_reg = n;
		xfer_base_init = 32'h0000_1000 + 32'(n);
		xfer_base_final = 32'h0000_2000 + 32'(n);
		@(negedge clk);
		{xfer_fault, xfer_irq} = 2'b00;
		chk(xfer_done_ff, f[9], "done");
		if (f[9])
		begin
			chk(base_value_ff, ef ? xfer_base_final : xfer_base_init, "base");
			chk(cont_wr_ff, wr, "field write");
			if (wr)
				chk(continuation_field_ff, rs ? CONT_NONE : n, "field");
			chk(restart_ff, rs, "restart");
		end
	endtask
	// number 0 stands for the original exception
	task automatic entry(input logic [3:0] sel, input logic hd, input mte_pri_t pp,
		input mte_pri_t lp, input mte_der_t cls, input mte_num_t tn, input mte_pri_t tp,
		input logic pv, input mte_num_t pn);
		mte_num_t on;
		on = 9'h010 + mte_num_t'(pp);
		orig_num = on;
		halt_debug_en = hd;
		preempt_pri = pp;
		entry_start = 1'b1;
		@(negedge clk);
		entry_start = 1'b0;
		chk(entry_busy_ff, 1'b1, "busy");
		err_sel = sel;
		err_go = |sel;
		@(negedge clk);
		err_go = 1'b0;
		entry_decide = 1'b1;
		late_req = 1'b1;
		late_pri = lp;
		@(negedge clk);
		entry_decide = 1'b0;
		late_req = 1'b0;
		chk(take_vld_ff, 1'b1, "take");
		chk(entry_busy_ff, 1'b0, "idle");
		chk(take_num_ff, tn == 0 ? on : tn, "take number");
		chk(take_pri_ff, tp, "take priority");
		chk(pend_vld_ff, pv, "pend");
		if (pv)
			chk(pend_num_ff, pn == 0 ? on : pn, "pend number");
		chk(der_class_ff, cls, "class");
		chk(der_drop_ff, cls == MTE_DER_WATCH, "drop");
	endtask

	// ==========================================================
	// scenarios
	task automatic test_xfer_fault();
		hit(10'b1100010000, 4'h5, 1'b0, 1'b1, 1'b1);
		hit(10'b1111010100, 4'h6, 1'b0, 1'b0, 1'b1);
		$display("transfer fault test done");
	endtask
	task automatic test_xfer_writeback();
		hit(10'b1010110100, 4'h2, 1'b0, 1'b0, 1'b1);
		hit(10'b1010111000, 4'h3, 1'b1, 1'b1, 1'b0);
		hit(10'b1011011000, 4'h2, 1'b0, 1'b1, 1'b0);
		hit(10'b1010010000, 4'h7, 1'b1, 1'b1, 1'b0);
		hit(10'b0010010000, 4'h1, 1'b0, 1'b0, 1'b0);
		$display("write-back test done");
	endtask
	task automatic test_base_load();
		hit(10'b1011000110, 4'h3, 1'b0, 1'b0, 1'b1);
		hit(10'b1011000010, 4'h1, 1'b0, 1'b1, 1'b0);
		hit(10'b1011000011, 4'h4, 1'b0, 1'b1, 1'b1);
		$display("base load test done");
	endtask
	task automatic test_late_arrival();
		entry(4'h0, 1'b0, 2, 1, MTE_DER_NONE, 9'h020, 1, 1'b1, 0);
		entry(4'h0, 1'b0, 2, 4, MTE_DER_NONE, 0, 4, 1'b0, 0);
		$display("late arrival test done");
	endtask
	task automatic test_derived();
		entry(4'h1, 1'b0, 2, 255, MTE_DER_VECTOR, EXC_HARD_FAULT, -1, 1'b1, 0);
		entry(4'h4, 1'b0, 2, 255, MTE_DER_BUS_STACK, EXC_HARD_FAULT, -1, 1'b1, 0);
		entry(4'h2, 1'b0, 2, 255, MTE_DER_WATCH, 0, 4, 1'b0, 0);
		entry(4'h8, 1'b0, 2, 255, MTE_DER_PROT_STACK, EXC_PROT_FAULT, 1, 1'b1, 0);
		entry(4'h4, 1'b0, 6, 255, MTE_DER_BUS_STACK, 0, 4, 1'b1, EXC_BUS_FAULT);
		entry(4'h2, 1'b1, 2, 255, MTE_DER_NONE, 0, 4, 1'b0, 0);
		$display("derived exception test done");
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		{rst_n, xfer_active, xfer_is_load, xfer_dir_db, xfer_writeback, xfer_base_is_sp} = 6'h0;
		{xfer_in_cond_block, xfer_base_in_list, xfer_base_loaded, xfer_fault, xfer_irq} = 5'h0;
		{entry_start, entry_decide, late_req, halt_debug_en, err_go, err_sel} = 9'h000;
		{xfer_next_reg, xfer_base_init, xfer_base_final} = '0;
		{orig_num, late_num, orig_pri, preempt_pri, late_pri} = '0;
		late_num = 9'h020;
		orig_pri = 9'sh004;
		prot_pri = 9'sh001;
		bus_pri = 9'sh005;
		watch_pri = 9'sh006;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		test_xfer_fault();
		test_xfer_writeback();
		test_base_load();
		test_late_arrival();
		test_derived();
		test_done();
	end
endmodule

`default_nettype wire
